// [eeprom_pkg.sv]
// Shared constants for the EEPROM program and erase control block.
package eeprom_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus and array geometry.
   localparam int unsigned ADDR_W       = 16;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned ARRAY_AW     = 9;
   localparam int unsigned ARRAY_BYTES  = 512;
   localparam logic [15:0] ARRAY_BASE   = 16'hb600;
   localparam logic [15:0] ARRAY_LAST   = 16'hb7ff;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets.
   localparam logic [15:0] PUMP_OPTION_ADDR        = 16'h1039;
   localparam logic [15:0] NV_PROGRAM_CONTROL_ADDR = 16'h103b;
   localparam logic [15:0] NV_SYSTEM_CONFIG_ADDR   = 16'h103f;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions of the programming control register.
   localparam int unsigned PC_HV_BIT    = 0;
   localparam int unsigned PC_LATCH_BIT = 1;
   localparam int unsigned PC_ERASE_BIT = 2;
   localparam int unsigned PC_ROW_BIT   = 3;
   localparam int unsigned PC_BYTE_BIT  = 4;
   localparam int unsigned PC_EVEN_BIT  = 6;
   localparam int unsigned PC_ODD_BIT   = 7;
   localparam logic [7:0]  PC_WRITE_MASK = 8'hdf;
   localparam logic [7:0]  PC_RESET      = 8'h00;

   // Pump clock select sits in bit 6 of the option register.
   localparam int unsigned OPT_PUMP_CLK_BIT = 6;
   localparam logic        OPT_RESET        = 1'b0;

   // Configuration cells: array enable in bit 0, erased value all ones.
   localparam int unsigned CFG_W           = 4;
   localparam int unsigned CFG_MAP_EN_BIT  = 0;
   localparam logic [3:0]  CFG_ERASED      = 4'hf;
   localparam logic [7:0]  ERASED_BYTE     = 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: least high-voltage time before an operation completes.
   localparam int unsigned CLK_HZ         = 125_000_000;
   localparam int unsigned HV_MIN_TIME_MS = 10;
   localparam int unsigned HV_MIN_CYCLES  = HV_MIN_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned HV_CNT_W       = 21;

   // Sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TIMING,
      ST_WALK,
      ST_HOLD
   } nv_state_t;

endpackage : eeprom_pkg

// [eeprom_program_erase_control.sv]
// EEPROM program and erase control with configuration cells and pump control.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
module eeprom_program_erase_control #(
   parameter int unsigned hv_min_cycles = eeprom_pkg::HV_MIN_CYCLES
) (
   // Clock and reset.
   input  wire logic                          ref_clk_in,
   input  wire logic                          rst_n_in,
   // Mode pin.
   input  wire logic                          special_mode_in,
   // Register and array port.
   input  wire logic [eeprom_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [eeprom_pkg::DATA_W-1:0] wr_data_in,
   input  wire logic                          wr_en_in,
   input  wire logic                          rd_en_in,
   output logic      [eeprom_pkg::DATA_W-1:0] rd_data_out,
   // Array and pump status.
   output logic                               array_map_enable_out,
   output logic                               pump_run_out,
   output logic                               pump_clock_select_out,
   output logic                               busy_out
);
   import eeprom_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   // Mode pin synchroniser.
   logic                mode_meta_reg;
   logic                mode_sync_reg;

   // Software registers and nonvolatile configuration cells. The cells
   // start erased and carry no reset, as they keep their value through
   // power loss.
   logic [7:0]          prog_ctrl_reg;
   logic                pump_clk_sel_reg;
   logic [CFG_W-1:0]    cfg_cells_reg = CFG_ERASED;
   logic [CFG_W-1:0]    cfg_visible_reg;

   // Captured target of the next high-voltage pulse.
   logic                armed_reg;
   logic                target_cfg_reg;
   logic [ARRAY_AW-1:0] target_addr_reg;
   logic [DATA_W-1:0]   target_data_reg;

   // Sequencer state, pulse timer and walk address.
   nv_state_t           state_reg;
   nv_state_t           state_next;
   logic [HV_CNT_W-1:0] hv_cnt_reg;
   logic [ARRAY_AW-1:0] walk_addr_reg;

   // Read data path.
   logic [DATA_W-1:0]   reg_rdata_reg;
   logic                rd_array_reg;
   logic [DATA_W-1:0]   mem_rdata;

   // Fields of the programming control register.
   logic                hv_bit;
   logic                latch_bit;
   logic                erase_bit;
   logic                row_bit;
   logic                byte_bit;
   logic                odd_bit;
   logic                even_bit;

   // Derived strobes and address decodes.
   logic                hv_active;
   logic                map_en;
   logic                hit_array;
   logic                hit_ctrl;
   logic                hit_option;
   logic                hit_config;
   logic                timer_done;
   logic                walk_hit;
   logic                walk_wr;
   logic                array_rd;
   logic [ARRAY_AW-1:0] bus_offset;
   logic [ARRAY_AW-1:0] mem_addr;

   ////////////////////////////////////////////////////////////////////////////
   // Field decode and address decode.
   assign hv_bit    = prog_ctrl_reg[PC_HV_BIT];
   assign latch_bit = prog_ctrl_reg[PC_LATCH_BIT];
   assign erase_bit = prog_ctrl_reg[PC_ERASE_BIT];
   assign row_bit   = prog_ctrl_reg[PC_ROW_BIT];
   assign byte_bit  = prog_ctrl_reg[PC_BYTE_BIT];
   assign odd_bit   = prog_ctrl_reg[PC_ODD_BIT];
   assign even_bit  = prog_ctrl_reg[PC_EVEN_BIT];

   // Voltage reaches the array only with the paths turned to programming.
   assign hv_active = hv_bit & latch_bit;
   assign map_en    = cfg_visible_reg[CFG_MAP_EN_BIT];

   // The array decodes only while mapped in.
   assign hit_array  = map_en && (addr_in >= ARRAY_BASE)
                       && (addr_in <= ARRAY_LAST);
   assign hit_ctrl   = (addr_in == NV_PROGRAM_CONTROL_ADDR);
   assign hit_option = (addr_in == PUMP_OPTION_ADDR);
   assign hit_config = (addr_in == NV_SYSTEM_CONFIG_ADDR);
   assign bus_offset = addr_in[ARRAY_AW-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Mode pin passes two flip-flops before any logic sees it.
   // The pin may change at any time; only the second stage is read, so
   // a late change simply delays the mode by one cycle.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         mode_meta_reg <= 1'b0;
         mode_sync_reg <= 1'b0;
      end else begin
         mode_meta_reg <= special_mode_in;
         mode_sync_reg <= mode_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Programming control register; bit 5 is not stored and reads zero.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         prog_ctrl_reg <= PC_RESET;
      end else if (wr_en_in && hit_ctrl) begin
         prog_ctrl_reg <= wr_data_in & PC_WRITE_MASK;
      end
   end

   // Pump clock select; software is expected to set it for slow clocks.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         pump_clk_sel_reg <= OPT_RESET;
      end else if (wr_en_in && hit_option) begin
         pump_clk_sel_reg <= wr_data_in[OPT_PUMP_CLK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Target capture. A write to the array, or in special mode to the configuration
   // address, while latched is not stored; it names the target of the next pulse.
   // Clearing the latch bit discards the target, so a stale address cannot
   // be hit by a later high-voltage pulse.
   // A write while the voltage is on is ignored, so the target cannot
   // move under a pulse that is already running.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         armed_reg       <= 1'b0;
         target_cfg_reg  <= 1'b0;
         target_addr_reg <= '0;
         target_data_reg <= '0;
      end else if (!latch_bit) begin
         armed_reg <= 1'b0;
      end else if (wr_en_in && !hv_bit && hit_array) begin
         armed_reg       <= 1'b1;
         target_cfg_reg  <= 1'b0;
         target_addr_reg <= bus_offset;
         target_data_reg <= wr_data_in;
      end else if (wr_en_in && !hv_bit && hit_config && mode_sync_reg) begin
         armed_reg       <= 1'b1;
         target_cfg_reg  <= 1'b1;
         target_data_reg <= wr_data_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: time the high voltage, then walk the array applying the
   // operation. Dropping the voltage before the timer ends abandons it with cells untouched;
   // real cells would be half written, which is no better a promise.
   // The walk visits every byte once, so row, bulk and byte operations
   // share one path and differ only in which bytes are hit. An array operation
   // lasts the pulse time plus one pass over the array; a configuration one has no walk.
   assign timer_done = (hv_cnt_reg == HV_CNT_W'(hv_min_cycles - 1));

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (hv_active && armed_reg) begin
               state_next = ST_TIMING;
            end
         end
         ST_TIMING: begin
            if (!hv_active) begin
               state_next = ST_IDLE;
            end else if (timer_done) begin
               state_next = target_cfg_reg ? ST_HOLD : ST_WALK;
            end
         end
         ST_WALK: begin
            if (!hv_active) begin
               state_next = ST_IDLE;
            end else if (walk_addr_reg == ARRAY_AW'(ARRAY_BYTES - 1)) begin
               state_next = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!hv_active) begin
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // High-voltage timer counts only while the pulse lasts.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         hv_cnt_reg <= '0;
      end else if (state_reg == ST_TIMING) begin
         hv_cnt_reg <= hv_cnt_reg + 1'b1;
      end else begin
         hv_cnt_reg <= '0;
      end
   end

   // Walk address steps once per cycle across the whole array.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         walk_addr_reg <= '0;
      end else if (state_reg == ST_WALK) begin
         walk_addr_reg <= walk_addr_reg + 1'b1;
      end else begin
         walk_addr_reg <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Which bytes the operation touches. A row is sixteen bytes, so the
   // row number is the address above bit 3. The odd and even test bits
   // repeat the target column in alternate rows of the target's half;
   // they exist for factory stress tests only.
   always_comb begin
      walk_hit = 1'b0;
      if (erase_bit) begin
         if (byte_bit) begin
            walk_hit = (walk_addr_reg == target_addr_reg);
         end else if (row_bit) begin
            walk_hit = (walk_addr_reg[ARRAY_AW-1:4]
                        == target_addr_reg[ARRAY_AW-1:4]);
         end else begin
            walk_hit = 1'b1;
         end
      end else if (odd_bit || even_bit) begin
         walk_hit = (walk_addr_reg[ARRAY_AW-1] == target_addr_reg[ARRAY_AW-1])
                    && (walk_addr_reg[3:0] == target_addr_reg[3:0])
                    && ((odd_bit && walk_addr_reg[4])
                        || (even_bit && !walk_addr_reg[4]));
      end else begin
         walk_hit = (walk_addr_reg == target_addr_reg);
      end
   end

   assign walk_wr  = (state_reg == ST_WALK) && hv_active && walk_hit;
   // Normal reads are served only with the latch clear.
   assign array_rd = rd_en_in && hit_array && !latch_bit;
   assign mem_addr = (state_reg == ST_WALK) ? walk_addr_reg : bus_offset;

   // The array port is shared: the walk owns the address while it runs,
   // and normal reads are refused then, because the latch bit is set.
   nv_byte_array array_inst (
      .ref_clk_in  (ref_clk_in),
      .addr_in     (mem_addr),
      .rd_en_in    (array_rd),
      .wr_en_in    (walk_wr),
      .wr_erase_in (erase_bit),
      .wr_data_in  (target_data_reg),
      .rd_data_out (mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Configuration cells hold no reset and start erased; the visible copy is
   // loaded from them only at reset, so a new value shows after the next one.
   // An update needs the special mode at capture and at pulse completion;
   // leaving the mode in between blocks the change.
   always_ff @(posedge ref_clk_in) begin
      if ((state_reg == ST_TIMING) && timer_done && hv_active
          && target_cfg_reg && mode_sync_reg) begin
         if (erase_bit) begin
            cfg_cells_reg <= CFG_ERASED;
         end else begin
            cfg_cells_reg <= cfg_cells_reg & target_data_reg[CFG_W-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         cfg_visible_reg <= cfg_cells_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read data, valid in the cycle after the read strobe.
   // Unknown addresses and refused array reads return zero, so software
   // never sees stale data from an earlier access.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         reg_rdata_reg <= '0;
         rd_array_reg  <= 1'b0;
      end else begin
         rd_array_reg  <= array_rd;
         reg_rdata_reg <= '0;
         if (rd_en_in && hit_ctrl) begin
            reg_rdata_reg <= prog_ctrl_reg;
         end else if (rd_en_in && hit_option) begin
            reg_rdata_reg <= 8'(pump_clk_sel_reg) << OPT_PUMP_CLK_BIT;
         end else if (rd_en_in && hit_config) begin
            reg_rdata_reg <= {4'h0, cfg_visible_reg};
         end
      end
   end

   assign rd_data_out = rd_array_reg ? mem_rdata : reg_rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Status outputs; the pump runs while voltage is commanded onto the array.
   // Busy covers the timer and the walk, not the hold that follows, as
   // software must still clear the high-voltage bit itself.
   assign array_map_enable_out  = map_en;
   assign pump_run_out          = hv_active;
   assign pump_clock_select_out = pump_clk_sel_reg;
   assign busy_out              = (state_reg == ST_TIMING)
                                  || (state_reg == ST_WALK);

endmodule : eeprom_program_erase_control

// [eeprom_program_erase_control_monitor.sv]
// Port checker for the EEPROM program and erase control block.
`timescale 1ns/100ps
module eeprom_program_erase_control_monitor #(
   parameter int unsigned hv_min_cycles = eeprom_pkg::HV_MIN_CYCLES
) (
   // Clock and reset.
   input wire logic                          ref_clk_in,
   input wire logic                          rst_n_in,
   // Inputs watched.
   input wire logic                          special_mode_in,
   input wire logic [eeprom_pkg::ADDR_W-1:0] addr_in,
   input wire logic [eeprom_pkg::DATA_W-1:0] wr_data_in,
   input wire logic                          wr_en_in,
   input wire logic                          rd_en_in,
   // Outputs watched.
   input wire logic [eeprom_pkg::DATA_W-1:0] rd_data_out,
   input wire logic                          array_map_enable_out,
   input wire logic                          pump_run_out,
   input wire logic                          pump_clock_select_out,
   input wire logic                          busy_out
);
   import eeprom_pkg::*;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   logic [23:0] busy_cnt_reg;
   logic        in_array;
   logic        known_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Counts busy cycles so the high-voltage time can be bounded both ways.
   always_ff @(posedge ref_clk_in) begin
      busy_cnt_reg <= (!rst_n_in || !busy_out) ? 24'h0 : busy_cnt_reg + 24'h1;
   end

   // Address decode kept apart so each read check stays short.
   assign in_array  = (addr_in >= ARRAY_BASE) && (addr_in <= ARRAY_LAST);
   assign known_reg = (addr_in == PUMP_OPTION_ADDR) ||
                      (addr_in == NV_PROGRAM_CONTROL_ADDR) ||
                      (addr_in == NV_SYSTEM_CONFIG_ADDR);

   ////////////////////////////////////////////////////////////////////////////
   // Request sequences shared by the properties below.
   sequence hv_start_s;
      wr_en_in && addr_in == NV_PROGRAM_CONTROL_ADDR && (&wr_data_in[1:0]);
   endsequence
   sequence hv_stop_s;
      wr_en_in && addr_in == NV_PROGRAM_CONTROL_ADDR && !wr_data_in[0];
   endsequence
   sequence rd_s(logic [15:0] a);
      rd_en_in && addr_in == a;
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   // Pump, sequencer, read-back and map enable checks.
   hv_start_a: assert property (hv_start_s |=> pump_run_out)
      else $error("pump did not start after high voltage write");
   hv_stop_a: assert property (hv_stop_s |=> !pump_run_out)
      else $error("pump did not stop after high voltage clear");
   busy_start_a: assert property ($rose(busy_out) |->
      pump_run_out && $past(pump_run_out))
      else $error("busy rose without a running pump");
   busy_bound_a: assert property (busy_cnt_reg <= hv_min_cycles + 600)
      else $error("operation ran too long");
   hv_time_min_a: assert property ($fell(busy_out) && pump_run_out |->
      busy_cnt_reg >= hv_min_cycles)
      else $error("operation ended before least high voltage time");
   pclk_write_a: assert property (wr_en_in && addr_in == PUMP_OPTION_ADDR |=>
      pump_clock_select_out == $past(wr_data_in[6]))
      else $error("pump clock select not taken from write");
   pclk_read_a: assert property (rd_s(PUMP_OPTION_ADDR) |=>
      rd_data_out == {1'b0, pump_clock_select_out, 6'h0})
      else $error("option read data wrong");
   ctrl_read_a: assert property (rd_s(NV_PROGRAM_CONTROL_ADDR) |=>
      !rd_data_out[5] && (&rd_data_out[1:0]) == pump_run_out)
      else $error("control read data disagrees with pump");
   cfg_read_a: assert property (rd_s(NV_SYSTEM_CONFIG_ADDR) |=> rd_data_out[7:4]
      == 4'h0 && rd_data_out[0] == array_map_enable_out)
      else $error("configuration read data wrong");
   unmapped_read_a: assert property (rd_en_in && !in_array && !known_reg |=>
      rd_data_out == 8'h00)
      else $error("unmapped read gave data");
   array_off_a: assert property (rd_en_in && in_array && !array_map_enable_out
      |=> rd_data_out == 8'h00)
      else $error("array answered while removed from map");
   map_hold_a: assert property (!$stable(array_map_enable_out) |->
      $past(rst_n_in) == 1'b0)
      else $error("map enable changed outside reset");
endmodule : eeprom_program_erase_control_monitor

bind eeprom_program_erase_control eeprom_program_erase_control_monitor #(
   .hv_min_cycles(hv_min_cycles)) i_mon (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
   .special_mode_in(special_mode_in), .addr_in(addr_in),
   .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
   .rd_data_out(rd_data_out), .array_map_enable_out(array_map_enable_out),
   .pump_run_out(pump_run_out), .pump_clock_select_out(pump_clock_select_out),
   .busy_out(busy_out));

// [nv_byte_array.sv]
// Nonvolatile byte array with registered read and program or erase writes.
`timescale 1ns/100ps
module nv_byte_array (
   // Clock.
   input  wire logic                           ref_clk_in,
   // Access port.
   input  wire logic [eeprom_pkg::ARRAY_AW-1:0] addr_in,
   input  wire logic                           rd_en_in,
   input  wire logic                           wr_en_in,
   input  wire logic                           wr_erase_in,
   input  wire logic [eeprom_pkg::DATA_W-1:0]  wr_data_in,
   // Read data.
   output logic      [eeprom_pkg::DATA_W-1:0]  rd_data_out
);
   import eeprom_pkg::*;

   logic [DATA_W-1:0] cells [ARRAY_BYTES] = '{default: ERASED_BYTE};

   ////////////////////////////////////////////////////////////////////////////
   // Cells leave the factory erased, through the initial value given above;
   // they hold no reset, being nonvolatile.

   // Programming can only clear bits, so new data is ANDed into the cell;
   // erasing returns the cell to all ones.
   always_ff @(posedge ref_clk_in) begin
      if (wr_en_in) begin
         if (wr_erase_in) begin
            cells[addr_in] <= ERASED_BYTE;
         end else begin
            cells[addr_in] <= cells[addr_in] & wr_data_in;
         end
      end
   end

   // Read data comes straight from a register.
   always_ff @(posedge ref_clk_in) begin
      if (rd_en_in) begin
         rd_data_out <= cells[addr_in];
      end
   end

endmodule : nv_byte_array

// [tb_top.sv]
// Self-checking bench for the EEPROM program and erase control block.
`timescale 1ns/100ps
module tb_top;
   import eeprom_pkg::*;
   typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   localparam int unsigned HV_SIM = 20;
   localparam logic [15:0] PC     = NV_PROGRAM_CONTROL_ADDR;
   logic        ref_clk_in, rst_n_in, special_mode_in, wr_en_in, rd_en_in;
   logic [15:0] addr_in;
   logic [7:0]  wr_data_in, rd_data_out, rd_val;
   logic        array_map_enable_out, pump_run_out;
   logic        pump_clock_select_out, busy_out;
   int          errors, total_checks, n;
   row_t        rows [10];

   eeprom_program_erase_control #(.hv_min_cycles(HV_SIM)) i_dut (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .special_mode_in(special_mode_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .rd_data_out(rd_data_out), .array_map_enable_out(array_map_enable_out),
      .pump_run_out(pump_run_out), .pump_clock_select_out(pump_clock_select_out),
      .busy_out(busy_out));

   ////////////////////////////////////////////////////////////////////////////
   // Free-running 125 MHz clock.
   initial begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end

   // Comparison and verdict tasks.
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8
   task automatic chk1(input string nm, input logic e, input logic g);
      chk8(nm, {7'h0, e}, {7'h0, g});
   endtask : chk1
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////////
   // Bus cycles: one-cycle strobes, read data taken in the following cycle.
   task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      addr_in    <= a;
      wr_data_in <= d;
      wr_en_in   <= 1'b1;
      @(posedge ref_clk_in);
      wr_en_in   <= 1'b0;
   endtask : bus_wr
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      @(posedge ref_clk_in);
      addr_in  <= a;
      rd_en_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_en_in <= 1'b0;
      #1 chk8($sformatf("read %h", a), e, rd_data_out);
   endtask : rd_chk
   task automatic do_reset;
      rst_n_in <= 1'b0;
      repeat (16) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      #1;
   endtask : do_reset

   // Full software sequence; short runs drop high voltage early.
   task automatic nv_op(input logic [7:0] c, input logic [15:0] a,
                        input logic [7:0] d, input bit full);
      bus_wr(PC, c);
      bus_wr(a, d);
      bus_wr(PC, c | 8'h01);
      #1 chk1("pump run", 1'b1, pump_run_out);
      repeat (3) @(posedge ref_clk_in);
      #1;
      n = 0;
      if (full && a != NV_SYSTEM_CONFIG_ADDR) begin
         chk1("busy", 1'b1, busy_out);
      end
      while (full && busy_out === 1'b1 && n < 2000) begin
         @(posedge ref_clk_in);
         #1;
         n++;
      end
      chk1("op done", 1'b1, n < 2000);
      bus_wr(PC, c);
      #1 chk1("pump off", 1'b0, pump_run_out);
      bus_wr(PC, 8'h00);
   endtask : nv_op

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog sized well above the roughly 6k cycles the tests need.
   initial begin
      #(8 * 40000);
      errors++;
      $display("[ERR] watchdog expected end seen timeout");
      tally_and_finish;
   end

   // Main sequence: reset, table of register rows, then awkward cases.
   initial begin
      {rst_n_in, special_mode_in, wr_en_in, rd_en_in} = 4'h0;
      addr_in = 16'h0000;
      wr_data_in = 8'h00;
      errors = 0;
      total_checks = 0;
      rows = '{'{PC, 8'hc0, 8'hc0}, '{PC, 8'h3c, 8'h1c}, '{PC, 8'h00, 8'h00},
         '{16'h1039, 8'hff, 8'h40}, '{16'h1039, 8'h00, 8'h00},
         '{16'h1000, 8'hff, 8'h00}, '{16'hb5ff, 8'h55, 8'h00},
         '{16'hb800, 8'h55, 8'h00}, '{16'hb600, 8'h00, 8'hff},
         '{16'hb7ff, 8'h00, 8'hff}};
      do_reset;
      chk1("pump run", 1'b0, pump_run_out);
      chk1("busy", 1'b0, busy_out);
      chk1("pump clock", 1'b0, pump_clock_select_out);
      chk1("map", 1'b1, array_map_enable_out);
      rd_chk(NV_SYSTEM_CONFIG_ADDR, 8'h0f);
      $display("Test reset done");
      foreach (rows[i]) begin
         bus_wr(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
      end
      $display("Test register table done");
      bus_wr(PC, 8'h02);
      rd_chk(16'hb605, 8'h00);
      nv_op(8'h02, 16'hb605, 8'h3c, 1'b1);
      rd_chk(16'hb605, 8'h3c);
      rd_chk(16'hb606, 8'hff);
      nv_op(8'h02, 16'hb605, 8'hc3, 1'b1);
      rd_chk(16'hb605, 8'h00);
      nv_op(8'h02, 16'hb606, 8'h00, 1'b0);
      rd_chk(16'hb606, 8'hff);
      $display("Test program done");
      nv_op(8'h02, 16'hb606, 8'h00, 1'b1);
      nv_op(8'h02, 16'hb615, 8'h00, 1'b1);
      nv_op(8'h16, 16'hb605, 8'h55, 1'b1);
      rd_chk(16'hb605, 8'hff);
      rd_chk(16'hb606, 8'h00);
      nv_op(8'h0e, 16'hb60a, 8'h55, 1'b1);
      rd_chk(16'hb606, 8'hff);
      rd_chk(16'hb615, 8'h00);
      nv_op(8'h02, 16'hb625, 8'h00, 1'b1);
      nv_op(8'h1e, 16'hb625, 8'h55, 1'b1);
      rd_chk(16'hb625, 8'hff);
      rd_chk(16'hb615, 8'h00);
      nv_op(8'h06, 16'hb7ff, 8'h55, 1'b1);
      rd_chk(16'hb615, 8'hff);
      $display("Test erase done");
      nv_op(8'h82, 16'hb605, 8'h00, 1'b1);
      rd_chk(16'hb615, 8'h00);
      rd_chk(16'hb625, 8'hff);
      rd_chk(16'hb715, 8'hff);
      $display("Test odd rows done");
      nv_op(8'h02, NV_SYSTEM_CONFIG_ADDR, 8'h0e, 1'b1);
      do_reset;
      rd_chk(NV_SYSTEM_CONFIG_ADDR, 8'h0f);
      special_mode_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      nv_op(8'h02, NV_SYSTEM_CONFIG_ADDR, 8'h0e, 1'b1);
      rd_chk(NV_SYSTEM_CONFIG_ADDR, 8'h0f);
      do_reset;
      chk1("map", 1'b0, array_map_enable_out);
      rd_chk(NV_SYSTEM_CONFIG_ADDR, 8'h0e);
      rd_chk(16'hb625, 8'h00);
      repeat (4) @(posedge ref_clk_in);
      nv_op(8'h16, NV_SYSTEM_CONFIG_ADDR, 8'h00, 1'b1);
      do_reset;
      chk1("map", 1'b1, array_map_enable_out);
      special_mode_in <= 1'b0;
      $display("Test configuration done");
      tally_and_finish;
   end
endmodule : tb_top
